// file: rwc_reset_ctrl.sv
// reset source gathering, reset status, system options and watchdog
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module rwc_reset_ctrl #(
    parameter int PERIPH_N = 8,
    parameter int PIN_N = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic reset_pin_n,
    input wire logic power_on_detect,
    input wire logic low_voltage_detect,
    input wire logic clk_1khz,
    input wire logic illegal_opcode_detect,
    input wire logic illegal_address_detect,
    input wire logic debugger_forced_reset,
    input wire logic stop_request,
    input wire logic stop_wakeup,
    input wire logic background_debug_mode,
    output logic cpu_reset,
    output logic pc_load,
    output logic [13:0] reset_pc,
    output logic stop_mode,
    output logic [PERIPH_N-1:0] periph_enable,
    output logic [PIN_N-1:0] pin_pull_enable,
    output logic [PIN_N-1:0] pin_output_enable
);
    if (PERIPH_N < 1 || PERIPH_N > 8) $error("PERIPH_N must be 1..8");
    if (PIN_N < 1 || PIN_N > 8) $error("PIN_N must be 1..8");

    ////////////////////////////////////////////////////////////////////////
    // pin inputs and 1 kHz tick

    logic [3:0] pins_s;
    logic clk_1khz_s;
    logic pin_n_s;
    logic por_s;
    logic lvd_s;
    logic clk_1khz_prev;
    logic tick;

    rwc_sync #(.W(4), .INIT(4'h4)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({clk_1khz, reset_pin_n, power_on_detect, low_voltage_detect}),
        .dout(pins_s)
    );

    assign clk_1khz_s = pins_s[3];
    assign pin_n_s = pins_s[2];
    assign por_s = pins_s[1];
    assign lvd_s = pins_s[0];
    assign tick = clk_1khz_s && !clk_1khz_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_1khz_prev <= 1'b0;
        end else begin
            clk_1khz_prev <= clk_1khz_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset sources and reset sequencing

    logic [7:0] status;
    logic [7:0] options;
    logic opt_locked;
    logic wdog_timeout;
    logic [7:0] cause;
    logic any_src;
    logic [2:0] hold_cnt;
    logic [2:0] next_hold_cnt;
    logic [7:0] next_status;
    logic next_cpu_reset;
    logic next_pc_load;

    always_comb begin
        cause = 8'h00;
        cause[rwc_pkg::ST_POR] = por_s;
        cause[rwc_pkg::ST_LVD] = lvd_s || por_s;
        cause[rwc_pkg::ST_PIN] = !pin_n_s && options[rwc_pkg::OPT_PIN_RST_EN];
        cause[rwc_pkg::ST_WDOG] = wdog_timeout;
        cause[rwc_pkg::ST_ILLEGAL_OPCODE_DETECT] = illegal_opcode_detect
            || (stop_request && !options[rwc_pkg::OPT_STOP_EN]);
        cause[rwc_pkg::ST_ILLEGAL_ADDRESS_DETECT] = illegal_address_detect;
        // the debugger reset has no flag and leaves every flag clear
        any_src = (|cause) || debugger_forced_reset;
    end

    always_comb begin
        next_status = status;
        next_hold_cnt = hold_cnt;
        next_pc_load = 1'b0;
        if (any_src) begin
            next_status = cause;
            next_hold_cnt = rwc_pkg::RESET_HOLD;
        end else if (hold_cnt != 3'h0) begin
            next_hold_cnt = hold_cnt - 3'h1;
            next_pc_load = (hold_cnt == 3'h1);
        end
        next_cpu_reset = (next_hold_cnt != 3'h0);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= rwc_pkg::STATUS_RESET;
            hold_cnt <= rwc_pkg::RESET_HOLD;
            cpu_reset <= 1'b1;
            pc_load <= 1'b0;
        end else begin
            status <= next_status;
            hold_cnt <= next_hold_cnt;
            cpu_reset <= next_cpu_reset;
            pc_load <= next_pc_load;
        end
    end

    assign reset_pc = rwc_pkg::RESET_PC;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    logic aw_full;
    logic w_full;
    logic [7:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic do_write;
    logic next_aw_full;
    logic next_w_full;
    logic [7:0] next_aw_q;
    logic [31:0] next_wd_q;
    logic [3:0] next_ws_q;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [7:0] wdog_count;

    assign awready = !aw_full && !bvalid;
    assign wready = !w_full && !bvalid;
    assign arready = !rvalid;
    assign do_write = aw_full && w_full && !bvalid;

    always_comb begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_aw_q = aw_q;
        next_wd_q = wd_q;
        next_ws_q = ws_q;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (awvalid && awready) begin
            next_aw_full = 1'b1;
            next_aw_q = awaddr;
        end
        if (wvalid && wready) begin
            next_w_full = 1'b1;
            next_wd_q = wdata;
            next_ws_q = wstrb;
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            case (aw_q)
                rwc_pkg::REG_STATUS,
                rwc_pkg::REG_OPTIONS,
                rwc_pkg::REG_PINCFG,
                rwc_pkg::REG_WDOG_COUNT: next_bresp = rwc_pkg::RESP_OKAY;
                default: next_bresp = rwc_pkg::RESP_SLVERR;
            endcase
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
    end

    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = rwc_pkg::RESP_OKAY;
            case (araddr)
                rwc_pkg::REG_STATUS: next_rdata = {24'h000000, status};
                rwc_pkg::REG_OPTIONS: next_rdata = {24'h000000, options};
                rwc_pkg::REG_PINCFG: next_rdata = {8'h00,
                    8'(pin_output_enable), 8'(pin_pull_enable), 8'(periph_enable)};
                rwc_pkg::REG_WDOG_COUNT: next_rdata = {24'h000000, wdog_count};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = rwc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h00000000;
            ws_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= rwc_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= rwc_pkg::RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            aw_q <= next_aw_q;
            wd_q <= next_wd_q;
            ws_q <= next_ws_q;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system options, pin configuration, power mode

    logic [7:0] next_options;
    logic next_opt_locked;
    logic [23:0] pincfg;
    logic [23:0] next_pincfg;
    logic wdog_clear;
    rwc_pkg::rwc_pmode_e pmode;
    rwc_pkg::rwc_pmode_e next_pmode;

    always_comb begin
        next_options = options;
        next_opt_locked = opt_locked;
        next_pincfg = pincfg;
        next_pmode = pmode;
        wdog_clear = 1'b0;
        if (any_src) begin
            // a system reset wins over any write in the same cycle
            next_options = rwc_pkg::OPTIONS_RESET;
            next_opt_locked = 1'b0;
            next_pincfg = rwc_pkg::PINCFG_RESET;
            next_pmode = rwc_pkg::PM_RUN;
            wdog_clear = 1'b1;
        end else begin
            if (do_write && aw_q == rwc_pkg::REG_STATUS) begin
                wdog_clear = 1'b1;
            end
            if (do_write && aw_q == rwc_pkg::REG_OPTIONS && ws_q[0] && !opt_locked) begin
                next_options = wd_q[7:0] & rwc_pkg::OPTIONS_MASK;
                next_opt_locked = 1'b1;
                wdog_clear = 1'b1;
            end
            if (do_write && aw_q == rwc_pkg::REG_PINCFG) begin
                for (int b = 0; b < 3; b++) begin
                    if (ws_q[b]) next_pincfg[8*b +: 8] = wd_q[8*b +: 8];
                end
            end
            case (pmode)
                rwc_pkg::PM_RUN: begin
                    if (stop_request) next_pmode = rwc_pkg::PM_STOP;
                end
                rwc_pkg::PM_STOP: begin
                    if (stop_wakeup) next_pmode = rwc_pkg::PM_RUN;
                end
                default: next_pmode = rwc_pkg::PM_RUN;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            options <= rwc_pkg::OPTIONS_RESET;
            opt_locked <= 1'b0;
            pincfg <= rwc_pkg::PINCFG_RESET;
            pmode <= rwc_pkg::PM_RUN;
        end else begin
            options <= next_options;
            opt_locked <= next_opt_locked;
            pincfg <= next_pincfg;
            pmode <= next_pmode;
        end
    end

    assign stop_mode = (pmode == rwc_pkg::PM_STOP);
    assign periph_enable = pincfg[PERIPH_N-1:0];
    assign pin_pull_enable = pincfg[8 +: PIN_N];
    assign pin_output_enable = pincfg[16 +: PIN_N];

    ////////////////////////////////////////////////////////////////////////
    // watchdog

    rwc_watchdog #(.CNT_W(rwc_pkg::WDOG_CNT_W)) u_wdog (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .clear(wdog_clear),
        .enable(options[rwc_pkg::OPT_WDOG_EN]),
        .long_sel(options[rwc_pkg::OPT_WDOG_LONG]),
        .freeze(background_debug_mode),
        .stop(stop_mode),
        .count(wdog_count),
        .timeout(wdog_timeout)
    );
endmodule

// file: rwc_pkg.sv
// constants shared by the reset and watchdog control block
// Functional notes
// - fetch starts at fixed top reset location
// - reset forces control and status registers
// - peripherals disabled, pins inputs without pulls
// - seven reset sources, pin gated by enable
// - every source except debugger has flag
// - status shows cause of latest reset
// - every reset sets watchdog enable bit
// - cleared enable stops watchdog, no resets
// - status address write clears watchdog counter
// - watchdog counts 1 kHz clock cycles
// - select bit picks 32 or 256, long default
// - overflow while enabled causes system reset
// - options register write once after reset
// - first options write clears watchdog counter
// - watchdog holds during background debug mode
// - stop entry zeroes counter, restarts on exit
// - power-on sets power-on and low-voltage flags
// - stop without enable forces illegal opcode reset
package rwc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_OPTIONS = 8'h04;
    localparam logic [7:0] REG_PINCFG = 8'h08;
    localparam logic [7:0] REG_WDOG_COUNT = 8'h0C;
    // reset status flag positions
    localparam int ST_POR = 7;
    localparam int ST_PIN = 6;
    localparam int ST_WDOG = 5;
    localparam int ST_ILLEGAL_OPCODE_DETECT = 4;
    localparam int ST_ILLEGAL_ADDRESS_DETECT = 3;
    localparam int ST_LVD = 1;
    localparam logic [7:0] STATUS_RESET = 8'h82;
    // system options field positions
    localparam int OPT_WDOG_EN = 7;
    localparam int OPT_WDOG_LONG = 6;
    localparam int OPT_STOP_EN = 5;
    localparam int OPT_PIN_RST_EN = 0;
    localparam logic [7:0] OPTIONS_MASK = 8'hE1;
    localparam logic [7:0] OPTIONS_RESET = 8'hC1;
    localparam logic [23:0] PINCFG_RESET = 24'h000000;
    // watchdog overflow: 2^5 or 2^8 ticks of the 1 kHz clock
    localparam int WDOG_CNT_W = 8;
    localparam logic [7:0] WDOG_SHORT_LAST = 8'h1F;
    localparam logic [7:0] WDOG_LONG_LAST = 8'hFF;
    localparam logic [13:0] RESET_PC = 14'h3FFD;
    // least time the core is held in reset
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RESET_HOLD_NS = 20;
    localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [2:0] RESET_HOLD = 3'(RESET_HOLD_CYCLES);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic {PM_RUN, PM_STOP} rwc_pmode_e;
endpackage

// file: rwc_sync.sv
// three-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module rwc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_dout;

    if (W < 1) $error("rwc_sync needs W >= 1");

    // a bit changes only once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            dout <= INIT;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            dout <= next_dout;
        end
    end
endmodule

// file: rwc_watchdog.sv
// watchdog counter advanced by 1 kHz ticks
`timescale 1ns/1ps
module rwc_watchdog #(
    parameter int CNT_W = rwc_pkg::WDOG_CNT_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic clear,
    input wire logic enable,
    input wire logic long_sel,
    input wire logic freeze,
    input wire logic stop,
    output logic [CNT_W-1:0] count,
    output logic timeout
);
    logic [CNT_W-1:0] next_count;
    logic next_timeout;
    logic [CNT_W-1:0] last;

    if (CNT_W < 8) $error("rwc_watchdog needs CNT_W >= 8");

    always_comb begin
        last = long_sel ? CNT_W'(rwc_pkg::WDOG_LONG_LAST)
                        : CNT_W'(rwc_pkg::WDOG_SHORT_LAST);
        next_count = count;
        next_timeout = 1'b0;
        if (clear || stop || !enable) begin
            next_count = '0;
        end else if (tick && !freeze) begin
            if (count == last) begin
                next_count = '0;
                next_timeout = 1'b1;
            end else begin
                next_count = count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            timeout <= 1'b0;
        end else begin
            count <= next_count;
            timeout <= next_timeout;
        end
    end
endmodule

// file: rwc_reset_ctrl_chk.sv
// concurrent checks on the ports of the reset and watchdog control block
`timescale 1ns/1ps
module rwc_reset_ctrl_chk #(
    parameter int PERIPH_N = 8,
    parameter int PIN_N = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic illegal_opcode_detect,
    input wire logic illegal_address_detect,
    input wire logic debugger_forced_reset,
    input wire logic stop_request,
    input wire logic stop_wakeup,
    input wire logic cpu_reset,
    input wire logic pc_load,
    input wire logic [13:0] reset_pc,
    input wire logic stop_mode,
    input wire logic [PERIPH_N-1:0] periph_enable,
    input wire logic [PIN_N-1:0] pin_pull_enable,
    input wire logic [PIN_N-1:0] pin_output_enable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    a_reset_pc: assert property (reset_pc == 14'h3FFD)
        else $error("reset location wrong");
    a_load_release: assert property (
        $fell(cpu_reset) |-> (pc_load || $past(pc_load)) or (##1 pc_load))
        else $error("no pc load at reset release");
    a_load_single: assert property (pc_load |=> !pc_load)
        else $error("pc load longer than one cycle");
    a_hold_min: assert property ($rose(cpu_reset) |=> cpu_reset [*3])
        else $error("core reset too short");
    a_sync_source: assert property (
        (illegal_opcode_detect || illegal_address_detect || debugger_forced_reset)
        |=> cpu_reset) else $error("source gave no reset");
    a_io_idle: assert property (
        cpu_reset |-> periph_enable == '0 && pin_pull_enable == '0 && pin_output_enable == '0)
        else $error("peripherals or pins active in reset");
    a_stop_refused: assert property (
        stop_request && !stop_mode && !cpu_reset |=> cpu_reset || stop_mode)
        else $error("stop request neither entered nor refused");
    a_stop_exit: assert property (stop_mode && stop_wakeup |=> ##[0:3] !stop_mode)
        else $error("stop not left on wakeup");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_read_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_write_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    c_release: cover property ($fell(cpu_reset));
    c_stop: cover property ($rose(stop_mode));
    c_read: cover property (rvalid && rready);
endmodule

bind rwc_reset_ctrl rwc_reset_ctrl_chk #(.PERIPH_N(PERIPH_N), .PIN_N(PIN_N)) i_chk (
    .aclk(aclk), .aresetn(aresetn), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rvalid(rvalid), .rready(rready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .illegal_opcode_detect(illegal_opcode_detect),
    .illegal_address_detect(illegal_address_detect),
    .debugger_forced_reset(debugger_forced_reset), .stop_request(stop_request),
    .stop_wakeup(stop_wakeup), .cpu_reset(cpu_reset), .pc_load(pc_load),
    .reset_pc(reset_pc), .stop_mode(stop_mode), .periph_enable(periph_enable),
    .pin_pull_enable(pin_pull_enable), .pin_output_enable(pin_output_enable));

// file: rwc_reset_ctrl_tb.sv
// self-checking bench for the reset and watchdog control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
$display("mismatch %s expected %h seen %h", nm, e, g); end end
module rwc_reset_ctrl_tb;
    localparam int P = 20; // aclk cycles per slow tick, sped up to keep the run short
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [5:0] src = 6'h00;
    logic clk_1khz = 1'b0;
    logic stop_request = 1'b0;
    logic stop_wakeup = 1'b0;
    logic bdm = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, cpu_reset, pc_load, stop_mode;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [13:0] reset_pc;
    logic [7:0] periph_enable, pin_pull_enable, pin_output_enable;
    logic [7:0] cause_tbl [6] = '{8'h82, 8'h02, 8'h10, 8'h08, 8'h00, 8'h40};
    int fails = 0;
    int n_checks = 0;
    int cyc_n = 0;
    int div = 0;

    rwc_reset_ctrl i_rwc_reset_ctrl (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .reset_pin_n(~src[5]), .power_on_detect(src[0]), .low_voltage_detect(src[1]),
        .clk_1khz(clk_1khz), .illegal_opcode_detect(src[2]),
        .illegal_address_detect(src[3]), .debugger_forced_reset(src[4]),
        .stop_request(stop_request), .stop_wakeup(stop_wakeup),
        .background_debug_mode(bdm), .cpu_reset(cpu_reset), .pc_load(pc_load),
        .reset_pc(reset_pc), .stop_mode(stop_mode), .periph_enable(periph_enable),
        .pin_pull_enable(pin_pull_enable), .pin_output_enable(pin_output_enable));

    initial forever #2.5 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////////////
    // slow tick source and hang guard
    always @(posedge aclk) begin
        div <= (div == P / 2 - 1) ? 0 : div + 1;
        if (div == P / 2 - 1) clk_1khz <= ~clk_1khz;
        cyc_n <= cyc_n + 1;
        if (cyc_n == 30000) begin
            fails++;
            complete_run;
        end
    end

    task complete_run;
        begin
            $display("checks %0d mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask

    task cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask

    // counts cycles until cpu_reset shows v, sampled away from the clock edge
    task automatic wait_lvl(input logic v, input int lim, output int n);
        begin
            n = 0;
            @(negedge aclk);
            while (cpu_reset !== v && n < lim) begin
                @(negedge aclk);
                n++;
            end
            @(posedge aclk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // bus master: ready flags are sampled at the falling edge, acted on at the next rise
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
            input logic [1:0] er = rwc_pkg::RESP_OKAY);
        int i;
        logic t_aw, t_w, t_b, v;
        logic [1:0] r;
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            wstrb <= s;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            for (i = 0; i < 50; i++) begin
                @(negedge aclk);
                t_aw = awvalid && awready;
                t_w = wvalid && wready;
                t_b = bvalid && bready;
                v = bvalid;
                r = bresp;
                @(posedge aclk);
                if (t_aw) awvalid <= 1'b0;
                if (t_w) wvalid <= 1'b0;
                if (t_b) begin
                    bready <= 1'b0;
                    break;
                end
                if (v) bready <= 1'b1;
            end
            `CHK("bresp", {1'b1, er}, {t_b, r})
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        logic t_ar, t_r, v;
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            for (i = 0; i < 50; i++) begin
                @(negedge aclk);
                t_ar = arvalid && arready;
                t_r = rvalid && rready;
                v = rvalid;
                d = rdata;
                r = rresp;
                @(posedge aclk);
                if (t_ar) arvalid <= 1'b0;
                if (t_r) begin
                    rready <= 1'b0;
                    break;
                end
                if (v) rready <= 1'b1;
            end
            `CHK("rvalid", 1'b1, t_r)
        end
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] er = rwc_pkg::RESP_OKAY);
        logic [31:0] d;
        logic [1:0] r;
        begin
            rd(a, d, r);
            `CHK(nm, {er, e}, {r, d})
        end
    endtask

    task automatic pulse(input int k);
        int n;
        begin
            src <= 6'(1 << k);
            cyc(8);
            src <= 6'h00;
            wait_lvl(1'b1, 20, n);
            wait_lvl(1'b0, 40, n);
            `CHK("release", 1'b1, n < 40)
        end
    endtask

    task automatic stop_pulse(input logic w);
        begin
            if (w) stop_wakeup <= 1'b1;
            else stop_request <= 1'b1;
            @(posedge aclk);
            stop_wakeup <= 1'b0;
            stop_request <= 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        int k;
        logic [31:0] d;
        logic [31:0] d0;
        logic [1:0] r;
        cyc(20);
        aresetn <= 1'b1;
        wait_lvl(1'b0, 40, n);
        `CHK("pc", 14'h3FFD, reset_pc)
        `CHK("io", 24'h0, {pin_output_enable, pin_pull_enable, periph_enable})
        rchk("status", rwc_pkg::REG_STATUS, 32'h82);
        rchk("options", rwc_pkg::REG_OPTIONS, 32'hC1);
        rchk("unmapped", 8'h10, 32'h0, rwc_pkg::RESP_SLVERR);
        wr(8'h10, 32'hFFFFFFFF, 4'hF, rwc_pkg::RESP_SLVERR);
        wr(rwc_pkg::REG_PINCFG, 32'h00A53C0F);
        `CHK("io_set", 24'hA53C0F, {pin_output_enable, pin_pull_enable, periph_enable})
        for (k = 0; k < 6; k++) begin
            pulse(k);
            rchk("cause", rwc_pkg::REG_STATUS, cause_tbl[k]);
            `CHK("io_off", 24'h0, {pin_output_enable, pin_pull_enable, periph_enable})
        end
        // pin source ignored once its enable is cleared
        wr(rwc_pkg::REG_OPTIONS, 32'hC0);
        src <= 6'h20;
        wait_lvl(1'b1, 12, n);
        `CHK("pin_off", 12, n)
        src <= 6'h00;
        cyc(8);
        stop_pulse(1'b0);
        wait_lvl(1'b1, 20, n);
        wait_lvl(1'b0, 40, n);
        rchk("stop_refused", rwc_pkg::REG_STATUS, 32'h10);
        wr(rwc_pkg::REG_OPTIONS, 32'hE1, 4'hE);
        rchk("no_lane0", rwc_pkg::REG_OPTIONS, 32'hC1);
        wr(rwc_pkg::REG_OPTIONS, 32'hE1);
        wr(rwc_pkg::REG_OPTIONS, 32'h41);
        rchk("locked", rwc_pkg::REG_OPTIONS, 32'hE1);
        stop_pulse(1'b0);
        cyc(5 * P);
        `CHK("stop_in", 1'b1, stop_mode)
        rd(rwc_pkg::REG_WDOG_COUNT, d, r);
        `CHK("stop_cnt", 32'h0, d)
        stop_pulse(1'b1);
        cyc(3 * P + 10);
        rd(rwc_pkg::REG_WDOG_COUNT, d, r);
        `CHK("restart", 1'b1, d > 0 && d < 5)
        cyc(10 * P);
        wr(rwc_pkg::REG_STATUS, 32'hFF);
        rd(rwc_pkg::REG_WDOG_COUNT, d, r);
        `CHK("cleared", 1'b1, d < 2)
        rchk("status_kept", rwc_pkg::REG_STATUS, 32'h10);
        bdm <= 1'b1;
        rd(rwc_pkg::REG_WDOG_COUNT, d0, r);
        cyc(10 * P);
        rd(rwc_pkg::REG_WDOG_COUNT, d, r);
        `CHK("frozen", d0, d)
        bdm <= 1'b0;
        // short timeout: refreshes keep it alive, then let it expire
        pulse(4);
        cyc(20 * P);
        wr(rwc_pkg::REG_OPTIONS, 32'h81);
        wr(rwc_pkg::REG_OPTIONS, 32'hC1);
        rchk("first_wins", rwc_pkg::REG_OPTIONS, 32'h81);
        for (k = 0; k < 3; k++) begin
            wait_lvl(1'b1, 25 * P, n);
            `CHK("refreshed", 25 * P, n)
            wr(rwc_pkg::REG_STATUS, 32'h00);
        end
        wait_lvl(1'b1, 40 * P, n);
        `CHK("short_to", 1'b1, n >= 31 * P - 10 && n <= 32 * P + 20)
        wait_lvl(1'b0, 40, n);
        rchk("wdog_cause", rwc_pkg::REG_STATUS, 32'h20);
        rchk("reenabled", rwc_pkg::REG_OPTIONS, 32'hC1);
        wait_lvl(1'b1, 300 * P, n);
        `CHK("long_to", 1'b1, n >= 255 * P - 10 && n <= 256 * P + 20)
        wait_lvl(1'b0, 40, n);
        wr(rwc_pkg::REG_OPTIONS, 32'h41);
        wait_lvl(1'b1, 270 * P, n);
        `CHK("disabled", 270 * P, n)
        rd(rwc_pkg::REG_WDOG_COUNT, d, r);
        `CHK("idle_cnt", 32'h0, d)
        complete_run;
    end
endmodule
